// ### rtl/mhi_interlock.sv
// multiplier hazard interlock for the memory_access_stage and fetch slot
// What this block does
// [RL1] second memory_access_stage of mult_acc_word never waits on leftover multiplier activity
// [RL2] back-to-back mult_acc_word accesses stay in issue order despite fetch contention
// [RL3] second mult_acc_word access colliding with fetch splits the slot as usual
// [RL4] signed_word_multiply reaches the multiplier only through a memory_access_stage grant
// [RL5] signed_word_multiply access waits in one stretched slot until multiplier finishes
// [RL6] with the multiplier idle, signed_word_multiply is granted without stall unless a fetch is owed
// [RL7] signed_word_multiply access colliding with fetch splits the slot
// [RL8] signed_double_multiply access after mult_acc_word is never stalled by busy multiplier
// [RL9] signed_double_multiply access colliding with fetch splits the slot
// [RL10] mult_acc_long keeps multiplier busy four cycles after its final access
// [RL11] decode after mult_acc_long is held back exactly one slot
// [RL12] mult_acc_word keeps multiplier busy two cycles after its second access
`timescale 1ns/1ps
module mhi_interlock
(
	input  wire logic                       I_CLOCK,
	input  wire logic                       I_RESET,
	input  wire logic                       I_MA_REQ,
	input  wire logic [mhi_pkg::OP_W-1:0]   I_MA_OP,
	input  wire logic                       I_IF_REQ,
	output logic                            O_MA_ACK,
	output logic                            O_IF_ACK,
	output logic                            O_MA_WAIT,
	output logic                            O_MULT_START,
	output logic                            O_MULT_BUSY,
	output logic                            O_ID_HOLD
);

	// slot ownership: free, or fetch owed after a split
	typedef enum logic [0:0] {ST_FREE, ST_IF_OWED} mhi_slot_e;

	mhi_slot_e                 slot_reg;
	mhi_slot_e                 slot_next;
	logic                      ma_ack_reg;
	logic                      if_ack_reg;
	logic                      ma_wait_reg;
	logic                      mult_start_reg;
	logic                      id_hold_reg;

	mhi_mult_if mult ();

	// true for operations whose memory_access_stage touches the multiplier
	function automatic logic uses_mult(input logic [mhi_pkg::OP_W-1:0] op);
		return (op == mhi_pkg::OP_MULT_ACC_WORD_B) || (op == mhi_pkg::OP_MULT_ACC_LONG_B) ||
			(op == mhi_pkg::OP_SIGNED_WORD_MUL) || (op == mhi_pkg::OP_SIGNED_DBL_MUL);
	endfunction

	// busy window that a granted multiplier access opens
	function automatic logic [mhi_pkg::CNT_W-1:0] busy_len(input logic [mhi_pkg::OP_W-1:0] op);
		logic [mhi_pkg::CNT_W-1:0] len;
		len = mhi_pkg::BUSY_CNT_WORD;
		if ((op == mhi_pkg::OP_MULT_ACC_LONG_B) || (op == mhi_pkg::OP_SIGNED_DBL_MUL))
			len = mhi_pkg::BUSY_CNT_LONG;
		return len;
	endfunction

	wire ma_new    = I_MA_REQ && !ma_ack_reg;
	wire if_new    = I_IF_REQ && !if_ack_reg;
	wire if_first  = (slot_reg == ST_IF_OWED) && if_new;
	wire op_mult   = uses_mult(I_MA_OP);

	// only signed_word_multiply waits on the running multiplier
	wire mult_wait = ma_new && (I_MA_OP == mhi_pkg::OP_SIGNED_WORD_MUL) && mult.busy; // RL5

	// grant the memory_access_stage unless the multiplier or an owed fetch blocks it
	wire ma_take   = ma_new && !mult_wait && !if_first; // RL1 RL6 RL8 RL2

	// fetch goes when owed, or when no access takes the bus this slot
	wire if_take   = if_new && (if_first || !ma_take); // RL3 RL7 RL9

	// a fetch that lost to an access is owed the following slot
	assign slot_next = (if_new && ma_take) ? ST_IF_OWED : ST_FREE; // RL3 RL7 RL9

	// multiplier access only through a granted memory_access_stage
	assign mult.load     = ma_take && op_mult; // RL4
	assign mult.load_cnt = busy_len(I_MA_OP);  // RL10 RL12

	mhi_busy_tracker u_busy
	(
		.i_clock (I_CLOCK),
		.i_reset (I_RESET),
		.mult    (mult)
	);

	// slot state
	always_ff @(posedge I_CLOCK or posedge I_RESET)
	begin
		if (I_RESET)
			slot_reg <= ST_FREE;
		else
			slot_reg <= slot_next;
	end

	// grant and status flops
	always_ff @(posedge I_CLOCK or posedge I_RESET)
	begin
		if (I_RESET)
		begin
			ma_ack_reg     <= 1'b0;
			if_ack_reg     <= 1'b0;
			ma_wait_reg    <= 1'b0;
			mult_start_reg <= 1'b0;
		end
		else
		begin
			ma_ack_reg     <= ma_take;
			if_ack_reg     <= if_take;
			ma_wait_reg    <= mult_wait; // RL5
			mult_start_reg <= mult.load; // RL4
		end
	end

	// decode held one slot after the final mult_acc_long access
	always_ff @(posedge I_CLOCK or posedge I_RESET)
	begin
		if (I_RESET)
			id_hold_reg <= 1'b0;
		else
			id_hold_reg <= ma_take && (I_MA_OP == mhi_pkg::OP_MULT_ACC_LONG_B); // RL11
	end

	// outputs straight from flops
	assign O_MA_ACK     = ma_ack_reg;
	assign O_IF_ACK     = if_ack_reg;
	assign O_MA_WAIT    = ma_wait_reg;
	assign O_MULT_START = mult_start_reg;
	assign O_MULT_BUSY  = mult.busy;
	assign O_ID_HOLD    = id_hold_reg;

	// checks on the interlock decisions
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RESET);

	property p_mw_no_stall;
		(ma_new && (I_MA_OP == mhi_pkg::OP_MULT_ACC_WORD_B) && !if_first) |=> O_MA_ACK;
	endproperty
	a_mw_no_stall: assert property (p_mw_no_stall) else $error("mult_acc_word access stalled"); // RL1

	property p_dmul_no_stall;
		(ma_new && (I_MA_OP == mhi_pkg::OP_SIGNED_DBL_MUL) && mult.busy && !if_first) |=> O_MA_ACK;
	endproperty
	a_dmul_no_stall: assert property (p_dmul_no_stall) else $error("double multiply stalled by busy"); // RL8

	property p_swm_waits;
		(I_MA_REQ && (I_MA_OP == mhi_pkg::OP_SIGNED_WORD_MUL) && mult.busy) |=> (!O_MA_ACK && O_MA_WAIT);
	endproperty
	a_swm_waits: assert property (p_swm_waits) else $error("word multiply granted while busy"); // RL5

	property p_swm_free;
		(ma_new && (I_MA_OP == mhi_pkg::OP_SIGNED_WORD_MUL) && !mult.busy && !if_first) |=> O_MA_ACK;
	endproperty
	a_swm_free: assert property (p_swm_free) else $error("word multiply stalled with idle multiplier"); // RL6

	property p_split_defers;
		(ma_take && if_new) |=> !O_IF_ACK;
	endproperty
	a_split_defers: assert property (p_split_defers) else $error("fetch not deferred on split"); // RL3

	property p_split_owed;
		(ma_take && if_new) ##1 I_IF_REQ |=> (O_IF_ACK && !O_MA_ACK);
	endproperty
	a_split_owed: assert property (p_split_owed) else $error("owed fetch not served next slot"); // RL7

	property p_start_via_ma;
		O_MULT_START |-> O_MA_ACK;
	endproperty
	a_start_via_ma: assert property (p_start_via_ma) else $error("multiplier started outside access"); // RL4

	property p_word_busy;
		(ma_take && (I_MA_OP == mhi_pkg::OP_MULT_ACC_WORD_B)) |=> O_MULT_BUSY[*2];
	endproperty
	a_word_busy: assert property (p_word_busy) else $error("word busy window too short"); // RL12

	property p_long_busy;
		(ma_take && (I_MA_OP == mhi_pkg::OP_MULT_ACC_LONG_B)) |=> O_MULT_BUSY[*4];
	endproperty
	a_long_busy: assert property (p_long_busy) else $error("long busy window too short"); // RL10

	property p_id_hold_one;
		(ma_take && (I_MA_OP == mhi_pkg::OP_MULT_ACC_LONG_B)) |=> O_ID_HOLD ##1 !O_ID_HOLD;
	endproperty
	a_id_hold_one: assert property (p_id_hold_one) else $error("decode hold not exactly one slot"); // RL11

	property p_single_grant;
		O_MA_ACK |=> !O_MA_ACK;
	endproperty
	a_single_grant: assert property (p_single_grant) else $error("access granted twice in a row"); // RL2

	property p_dmul_split;
		(ma_take && (I_MA_OP == mhi_pkg::OP_SIGNED_DBL_MUL) && if_new) |=> (O_MA_ACK && !O_IF_ACK);
	endproperty
	a_dmul_split: assert property (p_dmul_split) else $error("double multiply slot not split"); // RL9

	// main scenarios
	c_split:     cover property (ma_take && if_new ##1 O_MA_ACK ##1 O_IF_ACK);
	c_swm_wait:  cover property (mult_wait ##1 O_MA_WAIT ##1 O_MA_ACK);
	c_mw_busy:   cover property (mult.busy && ma_take && (I_MA_OP == mhi_pkg::OP_MULT_ACC_WORD_B));
	c_long_hold: cover property (O_ID_HOLD && O_MULT_BUSY);

endmodule // mhi_interlock

// ### rtl/mhi_pkg.sv
// constants for the multiplier hazard interlock
package mhi_pkg;

	// width of the operation code presented with a memory-access stage request
	localparam int OP_W = 3;

	// operation codes of the instruction sitting in the memory_access_stage
	localparam logic [2:0] OP_PLAIN_MEM       = 3'h0; // ordinary load/store or no multiplier use
	localparam logic [2:0] OP_MULT_ACC_WORD_A = 3'h1; // first memory_access_stage of mult_acc_word
	localparam logic [2:0] OP_MULT_ACC_WORD_B = 3'h2; // second memory_access_stage of mult_acc_word
	localparam logic [2:0] OP_MULT_ACC_LONG_A = 3'h3; // first memory_access_stage of mult_acc_long
	localparam logic [2:0] OP_MULT_ACC_LONG_B = 3'h4; // second memory_access_stage of mult_acc_long
	localparam logic [2:0] OP_SIGNED_WORD_MUL = 3'h5; // signed_word_multiply multiplier access
	localparam logic [2:0] OP_SIGNED_DBL_MUL  = 3'h6; // signed_double_multiply multiplier access

	// width of the multiplier_busy_cycle counter
	localparam int CNT_W = 3;

	// multiplier_busy_cycle counts after the final multiplier access
	localparam logic [2:0] BUSY_CNT_ZERO = 3'h0;
	localparam logic [2:0] BUSY_CNT_ONE  = 3'h1;
	localparam logic [2:0] BUSY_CNT_WORD = 3'h2; // word-sized products
	localparam logic [2:0] BUSY_CNT_LONG = 3'h4; // long and double-length products

endpackage

// ### rtl/mhi_mult_if.sv
// carrier between the interlock control and the multiplier busy tracker
`timescale 1ns/1ps
interface mhi_mult_if;

	logic                     load;     // multiplier access granted this cycle
	logic [mhi_pkg::CNT_W-1:0] load_cnt; // busy cycles the new access occupies
	logic                     busy;     // multiplier still operating
	logic [mhi_pkg::CNT_W-1:0] cnt;      // busy cycles still to run

	modport ctrl  (output load, output load_cnt, input busy, input cnt);
	modport track (input load, input load_cnt, output busy, output cnt);

endinterface

// ### rtl/mhi_busy_tracker.sv
// multiplier busy window counter
`timescale 1ns/1ps
module mhi_busy_tracker
(
	input  wire logic i_clock,
	input  wire logic i_reset,
	mhi_mult_if.track mult
);

	logic [mhi_pkg::CNT_W-1:0] cnt_reg;
	logic [mhi_pkg::CNT_W-1:0] cnt_next;
	logic                      busy_reg;

	// a new access restarts the window, otherwise count down to idle
	assign cnt_next = mult.load ? mult.load_cnt :
		(cnt_reg != mhi_pkg::BUSY_CNT_ZERO) ? cnt_reg - mhi_pkg::BUSY_CNT_ONE : mhi_pkg::BUSY_CNT_ZERO;

	// busy flag is its own flop so the top output stays registered
	always_ff @(posedge i_clock or posedge i_reset)
	begin
		if (i_reset)
		begin
			cnt_reg  <= mhi_pkg::BUSY_CNT_ZERO;
			busy_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			busy_reg <= (cnt_next != mhi_pkg::BUSY_CNT_ZERO);
		end
	end

	assign mult.cnt  = cnt_reg;
	assign mult.busy = busy_reg;

	// busy always agrees with the remaining count
	property p_busy_matches_cnt;
		@(posedge i_clock) disable iff (i_reset)
		mult.busy == (mult.cnt != mhi_pkg::BUSY_CNT_ZERO);
	endproperty
	a_busy_matches_cnt: assert property (p_busy_matches_cnt) else $error("busy flag disagrees with count");

endmodule // mhi_busy_tracker

// ### bench/tb.sv
// self-checking bench for the multiplier hazard interlock
`timescale 1ns/1ps
module tb;

	logic                     I_CLOCK;
	logic                     I_RESET;
	logic                     I_MA_REQ;
	logic [mhi_pkg::OP_W-1:0] I_MA_OP;
	logic                     I_IF_REQ;
	logic                     O_MA_ACK;
	logic                     O_IF_ACK;
	logic                     O_MA_WAIT;
	logic                     O_MULT_START;
	logic                     O_MULT_BUSY;
	logic                     O_ID_HOLD;
	int                       fails;
	int                       n_checks;

	mhi_interlock dut
	(
		.I_CLOCK      (I_CLOCK),
		.I_RESET      (I_RESET),
		.I_MA_REQ     (I_MA_REQ),
		.I_MA_OP      (I_MA_OP),
		.I_IF_REQ     (I_IF_REQ),
		.O_MA_ACK     (O_MA_ACK),
		.O_IF_ACK     (O_IF_ACK),
		.O_MA_WAIT    (O_MA_WAIT),
		.O_MULT_START (O_MULT_START),
		.O_MULT_BUSY  (O_MULT_BUSY),
		.O_ID_HOLD    (O_ID_HOLD)
	);

	// 25 MHz core clock
	always #20 I_CLOCK = ~I_CLOCK;

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// one access; returns with the request dropped, in its ack cycle, or one slot later after checking the owed fetch when ifr is set
	task automatic ma(input logic [2:0] op, input logic ifr, input int exp_lat);
		int k;
		int waits;
		k = 0;
		waits = 0;
		@(negedge I_CLOCK);
		I_MA_REQ = 1'b1;
		I_MA_OP = op;
		I_IF_REQ = ifr;
		@(negedge I_CLOCK);
		k++;
		while (O_MA_ACK !== 1'b1 && k < 12)
		begin
			if (O_MA_WAIT === 1'b1)
				waits++;
			@(negedge I_CLOCK);
			k++;
		end
		I_MA_REQ = 1'b0;
		chk("access latency", 8'(exp_lat), 8'(k));
		chk("wait cycles", 8'(exp_lat - 1), 8'(waits));
		chk("multiplier start", 8'(op inside {mhi_pkg::OP_MULT_ACC_WORD_B, mhi_pkg::OP_MULT_ACC_LONG_B,
			mhi_pkg::OP_SIGNED_WORD_MUL, mhi_pkg::OP_SIGNED_DBL_MUL}), 8'(O_MULT_START));
		if (ifr)
		begin
			chk("fetch in access slot", 8'h00, 8'(O_IF_ACK));
			@(negedge I_CLOCK);
			chk("fetch in next slot", 8'h01, 8'(O_IF_ACK));
			I_IF_REQ = 1'b0;
		end
	endtask

	// count busy and decode-hold cycles from the cycle ma returns in
	task automatic busy_len(input int exp_busy, input int exp_hold);
		int nb;
		int nh;
		nb = 0;
		nh = 0;
		while (O_MULT_BUSY === 1'b1 && nb < 10)
		begin
			nb++;
			if (O_ID_HOLD === 1'b1)
				nh++;
			@(negedge I_CLOCK);
		end
		chk("busy cycles", 8'(exp_busy), 8'(nb));
		chk("decode holds", 8'(exp_hold), 8'(nh));
		repeat (6) @(negedge I_CLOCK);
	endtask

	// first stages and plain accesses start nothing
	task automatic t_plain_codes;
		ma(mhi_pkg::OP_PLAIN_MEM, 1'b0, 1);
		ma(mhi_pkg::OP_MULT_ACC_WORD_A, 1'b0, 1);
		ma(mhi_pkg::OP_MULT_ACC_LONG_A, 1'b0, 1);
		ma(3'h7, 1'b0, 1);
		busy_len(0, 0);
	endtask

	// back-to-back pairs after a word accumulate
	task automatic t_pairs;
		ma(mhi_pkg::OP_MULT_ACC_WORD_B, 1'b0, 1);
		busy_len(2, 0);
		ma(mhi_pkg::OP_MULT_ACC_WORD_B, 1'b0, 1);
		ma(mhi_pkg::OP_MULT_ACC_WORD_B, 1'b0, 1);
		busy_len(2, 0);
		ma(mhi_pkg::OP_MULT_ACC_WORD_B, 1'b0, 1);
		ma(mhi_pkg::OP_SIGNED_WORD_MUL, 1'b0, 2);
		busy_len(2, 0);
		ma(mhi_pkg::OP_MULT_ACC_WORD_B, 1'b0, 1);
		ma(mhi_pkg::OP_SIGNED_DBL_MUL, 1'b0, 1);
		busy_len(4, 0);
		ma(mhi_pkg::OP_MULT_ACC_WORD_B, 1'b0, 1);
		ma(mhi_pkg::OP_PLAIN_MEM, 1'b0, 1);
		ma(mhi_pkg::OP_SIGNED_WORD_MUL, 1'b0, 1);
		busy_len(2, 0);
	endtask

	// long accumulate window and decode hold
	task automatic t_long;
		ma(mhi_pkg::OP_MULT_ACC_LONG_B, 1'b0, 1);
		busy_len(4, 1);
	endtask

	// access colliding with fetch splits the slot; the owed fetch slot uses one busy cycle
	task automatic t_split;
		ma(mhi_pkg::OP_MULT_ACC_WORD_B, 1'b1, 1);
		busy_len(1, 0);
		ma(mhi_pkg::OP_SIGNED_WORD_MUL, 1'b1, 1);
		busy_len(1, 0);
		ma(mhi_pkg::OP_SIGNED_DBL_MUL, 1'b1, 1);
		busy_len(3, 0);
	endtask

	// watchdog sized well past the scenario run time
	initial
	begin
		#200000;
		fails++;
		report_and_stop();
	end

	// reset, then the scenarios
	initial
	begin
		fails = 0;
		n_checks = 0;
		I_CLOCK = 1'b0;
		I_RESET = 1'b1;
		I_MA_REQ = 1'b0;
		I_MA_OP = mhi_pkg::OP_PLAIN_MEM;
		I_IF_REQ = 1'b0;
		repeat (10) @(negedge I_CLOCK);
		I_RESET = 1'b0;
		chk("busy after reset", 8'h00, 8'(O_MULT_BUSY));
		t_plain_codes();
		t_pairs();
		t_long();
		t_split();
		report_and_stop();
	end

endmodule // tb
